// file: counter_array_capture_compare.sv
// Counter array: shared counter, timebase, flags, register port and six channels
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Six capture/compare modules share one counter, each in its own mode.
// - All 8 to 11-bit PWM modules share one cycle-length setting.
// - Mode bit 0 gates the module event flag onto the interrupt request.
// - Mode bits 3-1 clear selects capture; bits 5/4 pick rising/falling/both.
// - Software timer: comparator and match flag enable set, others clear.
// - High-speed output: toggle, match flag and comparator enable set.
// - Frequency output: comparator, toggle and PWM select set, no capture bits.
// - Low-width PWM: PWM select only; shared field picks 8, 9, 10, 11 bits.
// - 16-bit PWM: wide select with PWM select; cycle length ignored.
// - Comparator off: no toggling in output modes, PWM output held low.
// - Reload view bit steers compare bytes to reload pair in 9-11 bit PWM.
// - With match flag enable set, a comparator match sets the event flag.
// - PWM config bit 5 enables interrupt on low-width overflow.
// - Capture edge copies the counter into the compare pair and sets flag.
// - Event flags are never cleared by hardware; software writes zero.
// - In both-edge capture, the pin level read tells which edge fired.
// - Software timer compares all 16 counter bits, flag on equality.
// - Low byte write clears comparator enable; high byte write sets it.
// - High-speed output inverts the pin on each 16-bit match.
// - Frequency output: low byte match toggles pin, high byte added.
// - High byte is half-period in ticks; zero means 256 ticks.
// - Low-width overflow flag sets on overflow of the selected bit.
// - Timebase select: code 000 is clock over 12, 100 is clock.
module counter_array_capture_compare
  import cacc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [7:0]        sfr_addr,
  input  wire logic [7:0]        sfr_wdata,
  input  wire logic              sfr_wr,
  input  wire logic              sfr_rd,
  output var  logic [7:0]        sfr_rdata,
  input  wire logic              timer0_ovf_tick,
  input  wire logic              ext_osc_tick,
  input  wire logic              rtc_tick,
  input  wire logic              eci_pin,
  input  wire logic [NUM_CH-1:0] module_pin_in,
  output logic [NUM_CH-1:0]      module_pin_out,
  output logic [NUM_CH-1:0]      module_pin_oe_n,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0]       count_q;
  logic              count_new_q;
  logic [7:0]        snap_high_q;
  logic [3:0]        div_q;
  logic              div_tick;
  logic              tick;
  logic              run_q;
  logic [2:0]        tb_sel_q;
  logic [7:0]        pwm_cfg_q;
  logic [NUM_CH-1:0] event_flag_q;
  logic [NUM_CH-1:0] pin_sync;
  logic              eci_sync;
  logic              eci_prev_q;
  logic              ovf_lw;
  logic [NUM_CH-1:0] ch_event;
  logic [NUM_CH-1:0] ch_irq_en;
  logic [NUM_CH-1:0] ch_drive;
  logic [7:0]        ch_mode  [NUM_CH];
  logic [7:0]        ch_low   [NUM_CH];
  logic [7:0]        ch_high  [NUM_CH];
  cacc_wr_s          ch_wr    [NUM_CH];
  logic [7:0]        rd_value;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Sources must hold each level two clocks or the sampled edge can vanish
  cacc_sync #(.W(NUM_CH)) u_pin_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (module_pin_in),
    .sync_out (pin_sync)
  );

  cacc_sync #(.W(1)) u_eci_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (eci_pin),
    .sync_out (eci_sync)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      eci_prev_q <= 1'b0;
    end else begin
      eci_prev_q <= eci_sync;
    end
  end

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 4'h0;
    end else if (div_tick) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  assign div_tick = (tb_sel_q == TB_DIV4) ? (div_q >= DIV4_LAST) : (div_q >= DIV12_LAST);

  always_comb begin
    tick = 1'b0;
    unique case (tb_sel_q)
      TB_DIV12: tick = div_tick;
      TB_DIV4:  tick = div_tick;
      TB_T0:    tick = timer0_ovf_tick;
      TB_ECI:   tick = eci_prev_q && !eci_sync;
      TB_SYS:   tick = 1'b1;
      TB_EXT:   tick = ext_osc_tick;
      TB_RTC:   tick = rtc_tick;
      default:  tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Shared counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= CNT_RST;
    end else if (sfr_wr && sfr_addr == ADDR_CNT_LOW) begin
      count_q[7:0] <= sfr_wdata;
    end else if (sfr_wr && sfr_addr == ADDR_CNT_HIGH) begin
      count_q[15:8] <= sfr_wdata;
    end else if (run_q && tick) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // Channels compare the count one clock after it moves, never on a stale value
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_new_q <= 1'b0;
    end else begin
      count_new_q <= run_q && tick;
    end
  end

  // Reading the low byte freezes the high byte so a 16-bit read is coherent
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      snap_high_q <= 8'h00;
    end else if (sfr_rd && sfr_addr == ADDR_CNT_LOW) begin
      snap_high_q <= count_q[15:8];
    end
  end

  assign ovf_lw = count_new_q && ((count_q & lw_mask(pwm_cfg_q[1:0])) == 16'h0000);

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_q <= 1'b0;
    end else if (sfr_wr && sfr_addr == ADDR_ARRAY_CTRL) begin
      run_q <= sfr_wdata[CTRL_RUN_BIT];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tb_sel_q <= 3'h0;
    end else if (sfr_wr && sfr_addr == ADDR_ARRAY_MODE) begin
      tb_sel_q <= sfr_wdata[TB_SEL_LSB +: 3];
    end
  end

  // Overflow flag: hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pwm_cfg_q <= PWM_RST;
    end else begin
      if (sfr_wr && sfr_addr == ADDR_PWM_CFG) begin
        pwm_cfg_q <= sfr_wdata;
      end
      if (ovf_lw) begin
        pwm_cfg_q[PWM_LOW_WIDTH_OVERFLOW_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // Flags clear only by software write; a same-cycle event still sets them
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      event_flag_q <= '0;
    end else if (sfr_wr && sfr_addr == ADDR_ARRAY_CTRL) begin
      event_flag_q <= sfr_wdata[NUM_CH-1:0] | ch_event;
    end else begin
      event_flag_q <= event_flag_q | ch_event;
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      cacc_mode_s mode_w;

      assign ch_wr[i].mode_wr = sfr_wr && (sfr_addr == ADDR_MODE_BASE + 8'(i));
      assign ch_wr[i].cpl_wr  = sfr_wr && (sfr_addr == ADDR_CPL_BASE + 8'(i));
      assign ch_wr[i].cph_wr  = sfr_wr && (sfr_addr == ADDR_CPH_BASE + 8'(i));
      assign ch_wr[i].data    = sfr_wdata;

      cacc_channel u_ch (
        .clk         (clk),
        .reset_n     (reset_n),
        .wr          (ch_wr[i]),
        .reload_view (pwm_cfg_q[PWM_VIEW_BIT]),
        .cycle_len   (pwm_cfg_q[1:0]),
        .count       (count_q),
        .count_new   (count_new_q),
        .pin_level   (pin_sync[i]),
        .mode_q      (mode_w),
        .view_low    (ch_low[i]),
        .view_high   (ch_high[i]),
        .event_pulse (ch_event[i]),
        .pin_out_q   (module_pin_out[i]),
        .pin_drive   (ch_drive[i])
      );

      assign ch_mode[i]         = mode_w;
      assign ch_irq_en[i]       = mode_w.match_irq_enable;
      assign module_pin_oe_n[i] = !ch_drive[i];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  assign irq = (|(event_flag_q & ch_irq_en)) ||
               (pwm_cfg_q[PWM_LOW_WIDTH_OVERFLOW_FLAG_BIT] && pwm_cfg_q[PWM_OVERFLOW_IRQ_ENABLE_BIT]);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_value = 8'h00;
    if (sfr_addr == ADDR_ARRAY_CTRL) begin
      rd_value = {1'b0, run_q, event_flag_q};
    end else if (sfr_addr == ADDR_ARRAY_MODE) begin
      rd_value = {4'h0, tb_sel_q, 1'b0};
    end else if (sfr_addr == ADDR_PWM_CFG) begin
      rd_value = pwm_cfg_q;
    end else if (sfr_addr == ADDR_CNT_LOW) begin
      rd_value = count_q[7:0];
    end else if (sfr_addr == ADDR_CNT_HIGH) begin
      rd_value = snap_high_q;
    end else if (sfr_addr == ADDR_PIN_LEVEL) begin
      rd_value = {2'h0, pin_sync};
    end
    for (int k = 0; k < NUM_CH; k++) begin
      if (sfr_addr == ADDR_MODE_BASE + 8'(k)) begin
        rd_value = ch_mode[k];
      end
      if (sfr_addr == ADDR_CPL_BASE + 8'(k)) begin
        rd_value = ch_low[k];
      end
      if (sfr_addr == ADDR_CPH_BASE + 8'(k)) begin
        rd_value = ch_high[k];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata <= rd_value;
    end
  end

endmodule

`default_nettype wire

// file: cacc_pkg.sv
// Shared constants, types and decode functions for the counter array capture/compare block
`default_nettype none

package cacc_pkg;

  // ----------------------------------------------------------------
  // Structure
  // ----------------------------------------------------------------
  localparam int NUM_CH = 6;

  // ----------------------------------------------------------------
  // Register addresses on the special function register port
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ARRAY_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ARRAY_MODE = 8'h01;
  localparam logic [7:0] ADDR_PWM_CFG    = 8'h02;
  localparam logic [7:0] ADDR_CNT_LOW    = 8'h03;
  localparam logic [7:0] ADDR_CNT_HIGH   = 8'h04;
  localparam logic [7:0] ADDR_PIN_LEVEL  = 8'h05;
  localparam logic [7:0] ADDR_MODE_BASE  = 8'h10;
  localparam logic [7:0] ADDR_CPL_BASE   = 8'h20;
  localparam logic [7:0] ADDR_CPH_BASE   = 8'h28;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RUN_BIT  = 6;
  localparam int PWM_VIEW_BIT  = 7;
  localparam int PWM_LOW_WIDTH_OVERFLOW_FLAG_BIT  = 6;
  localparam int PWM_OVERFLOW_IRQ_ENABLE_BIT  = 5;
  localparam int TB_SEL_LSB    = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  MODE_RST = 8'h00;
  localparam logic [7:0]  PWM_RST  = 8'h00;
  localparam logic [15:0] CC_RST   = 16'h0000;
  localparam logic [15:0] CNT_RST  = 16'h0000;

  // ----------------------------------------------------------------
  // Timebase codes and prescaler counts
  // ----------------------------------------------------------------
  localparam logic [2:0] TB_DIV12 = 3'h0;
  localparam logic [2:0] TB_DIV4  = 3'h1;
  localparam logic [2:0] TB_T0    = 3'h2;
  localparam logic [2:0] TB_ECI   = 3'h3;
  localparam logic [2:0] TB_SYS   = 3'h4;
  localparam logic [2:0] TB_EXT   = 3'h5;
  localparam logic [2:0] TB_RTC   = 3'h6;
  localparam logic [3:0] DIV12_LAST = 4'hB;
  localparam logic [3:0] DIV4_LAST  = 4'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wide_pwm_select;
    logic comparator_enable;
    logic rise_capture_sel;
    logic fall_capture_sel;
    logic match_flag_enable;
    logic toggle_on_match;
    logic pwm_select;
    logic match_irq_enable;
  } cacc_mode_s;

  typedef enum logic [6:0] {
    OP_NONE = 7'h01,
    OP_CAP  = 7'h02,
    OP_TMR  = 7'h04,
    OP_HSO  = 7'h08,
    OP_FRQ  = 7'h10,
    OP_PWML = 7'h20,
    OP_PWMW = 7'h40
  } cacc_op_e;

  typedef struct packed {
    logic       mode_wr;
    logic       cpl_wr;
    logic       cph_wr;
    logic [7:0] data;
  } cacc_wr_s;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic cacc_op_e op_decode(input cacc_mode_s m);
    cacc_op_e op;
    op = OP_NONE;
    if (m.rise_capture_sel || m.fall_capture_sel) begin
      if (!m.match_flag_enable && !m.toggle_on_match && !m.pwm_select) begin
        op = OP_CAP;
      end
    end else if (m.pwm_select) begin
      if (m.wide_pwm_select) begin
        op = OP_PWMW;
      end else if (m.toggle_on_match) begin
        op = OP_FRQ;
      end else begin
        op = OP_PWML;
      end
    end else if (m.toggle_on_match && m.match_flag_enable) begin
      op = OP_HSO;
    end else if (m.match_flag_enable) begin
      op = OP_TMR;
    end
    return op;
  endfunction

  function automatic logic [15:0] lw_mask(input logic [1:0] cls);
    logic [15:0] m;
    m = 16'h00FF;
    unique case (cls)
      2'h0: m = 16'h00FF;
      2'h1: m = 16'h01FF;
      2'h2: m = 16'h03FF;
      2'h3: m = 16'h07FF;
    endcase
    return m;
  endfunction

endpackage

`default_nettype wire

// file: cacc_sync.sv
// Two-stage synchroniser for asynchronous input levels
`timescale 1ns/100ps
`default_nettype none

module cacc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

// file: cacc_channel.sv
// One capture/compare module: mode register, compare pair, reload pair and pin logic
`timescale 1ns/100ps
`default_nettype none

module cacc_channel
  import cacc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire cacc_wr_s    wr,
  input  wire logic        reload_view,
  input  wire logic [1:0]  cycle_len,
  input  wire logic [15:0] count,
  input  wire logic        count_new,
  input  wire logic        pin_level,
  output var  cacc_mode_s  mode_q,
  output logic [7:0]       view_low,
  output logic [7:0]       view_high,
  output logic             event_pulse,
  output var  logic        pin_out_q,
  output logic             pin_drive
);

  logic [15:0] cc_q;
  logic [15:0] reload_q;
  logic        prev_q;
  cacc_op_e    op;
  logic [15:0] mask;
  logic        use_reload;
  logic        edge_hit;
  logic        match16;
  logic        match8;
  logic        match_lw;
  logic        ovf_lw;
  logic        ovf16;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign op         = op_decode(mode_q);
  assign mask       = lw_mask(cycle_len);
  assign use_reload = reload_view && (op == OP_PWML) && (cycle_len != 2'h0);
  assign view_low   = use_reload ? reload_q[7:0] : cc_q[7:0];
  assign view_high  = use_reload ? reload_q[15:8] : cc_q[15:8];
  // Comparators only look at a freshly advanced count, so one value matches once
  assign match16    = mode_q.comparator_enable && count_new && (count == cc_q);
  assign match8     = mode_q.comparator_enable && count_new && (count[7:0] == cc_q[7:0]);
  assign match_lw   = mode_q.comparator_enable && count_new && ((count & mask) == (cc_q & mask));
  assign ovf_lw     = count_new && ((count & mask) == 16'h0000);
  assign ovf16      = count_new && (count == 16'h0000);
  assign edge_hit   = (op == OP_CAP) &&
                      ((mode_q.rise_capture_sel && pin_level && !prev_q) ||
                       (mode_q.fall_capture_sel && !pin_level && prev_q));
  assign pin_drive  = (op == OP_HSO) || (op == OP_FRQ) || (op == OP_PWML) || (op == OP_PWMW);

  always_comb begin
    event_pulse = 1'b0;
    unique case (op)
      OP_CAP:  event_pulse = edge_hit;
      OP_TMR:  event_pulse = match16 && mode_q.match_flag_enable;
      OP_HSO:  event_pulse = match16 && mode_q.match_flag_enable;
      OP_FRQ:  event_pulse = match16 && mode_q.match_flag_enable;
      OP_PWML: event_pulse = match_lw && mode_q.match_flag_enable;
      OP_PWMW: event_pulse = match16 && mode_q.match_flag_enable;
      OP_NONE: event_pulse = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= cacc_mode_s'(MODE_RST);
    end else if (wr.mode_wr) begin
      mode_q <= cacc_mode_s'(wr.data);
    end else if (wr.cpl_wr) begin
      mode_q.comparator_enable <= 1'b0;
    end else if (wr.cph_wr) begin
      mode_q.comparator_enable <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Compare and reload pairs; software byte writes override hardware
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cc_q     <= CC_RST;
      reload_q <= CC_RST;
    end else begin
      if (edge_hit) begin
        cc_q <= count;
      end else if (op == OP_FRQ && match8) begin
        // A high byte of zero adds 256, which wraps back to the same low byte
        cc_q[7:0] <= cc_q[7:0] + cc_q[15:8];
      end else if (op == OP_PWML && ovf_lw) begin
        if (cycle_len == 2'h0) begin
          cc_q[7:0] <= cc_q[15:8];
        end else begin
          cc_q <= reload_q;
        end
      end
      if (wr.cpl_wr) begin
        if (use_reload) begin
          reload_q[7:0] <= wr.data;
        end else begin
          cc_q[7:0] <= wr.data;
        end
      end
      if (wr.cph_wr) begin
        if (use_reload) begin
          reload_q[15:8] <= wr.data;
        end else begin
          cc_q[15:8] <= wr.data;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin history and pin output
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= pin_level;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_out_q <= 1'b0;
    end else begin
      unique case (op)
        OP_HSO: begin
          if (match16) begin
            pin_out_q <= !pin_out_q;
          end
        end
        OP_FRQ: begin
          if (match8) begin
            pin_out_q <= !pin_out_q;
          end
        end
        OP_PWML: begin
          // Match takes priority over overflow so a zero compare value gives full duty
          if (!mode_q.comparator_enable) begin
            pin_out_q <= 1'b0;
          end else if (match_lw) begin
            pin_out_q <= 1'b1;
          end else if (ovf_lw) begin
            pin_out_q <= 1'b0;
          end
        end
        OP_PWMW: begin
          if (!mode_q.comparator_enable) begin
            pin_out_q <= 1'b0;
          end else if (match16) begin
            pin_out_q <= 1'b1;
          end else if (ovf16) begin
            pin_out_q <= 1'b0;
          end
        end
        OP_CAP, OP_TMR, OP_NONE: pin_out_q <= pin_out_q;
      endcase
    end
  end

endmodule

`default_nettype wire

// file: counter_array_capture_compare_sva.sv
// Port-level assertions for the counter array capture/compare block
`timescale 1ns/100ps
`default_nettype none
module cacc_checker
  import cacc_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic [7:0]        sfr_addr,
  input wire logic [7:0]        sfr_wdata,
  input wire logic              sfr_wr,
  input wire logic              sfr_rd,
  input wire logic [7:0]        sfr_rdata,
  input wire logic [NUM_CH-1:0] module_pin_in,
  input wire logic [NUM_CH-1:0] module_pin_out,
  input wire logic [NUM_CH-1:0] module_pin_oe_n,
  input wire logic              irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_mode_rb; sfr_wr && sfr_addr == ADDR_MODE_BASE ##2 sfr_rd && sfr_addr ==
    ADDR_MODE_BASE |=> sfr_rdata == $past(sfr_wdata, 3); endproperty
  a_mode_rb: assert property (p_mode_rb) else $error("mode readback wrong");
  property p_lo; sfr_wr && sfr_addr == ADDR_CPL_BASE ##2 sfr_rd && sfr_addr ==
    ADDR_MODE_BASE |=> !sfr_rdata[6]; endproperty
  a_lo: assert property (p_lo) else $error("low byte kept compare on");
  property p_hi; sfr_wr && sfr_addr == ADDR_CPH_BASE ##2 sfr_rd && sfr_addr ==
    ADDR_MODE_BASE |=> sfr_rdata[6]; endproperty
  a_hi: assert property (p_hi) else $error("high byte left compare off");
  property p_irqf; $fell(irq) |-> $past(sfr_wr); endproperty
  a_irqf: assert property (p_irqf) else $error("flag cleared by hardware");
  property p_oe; $changed(module_pin_oe_n) |-> $past(sfr_wr); endproperty
  a_oe: assert property (p_oe) else $error("pin drive changed alone");
  property p_pin; $stable(module_pin_in)[*4] ##0 (sfr_rd && sfr_addr == ADDR_PIN_LEVEL)
    |=> sfr_rdata == {2'h0, $past(module_pin_in)}; endproperty
  a_pin: assert property (p_pin) else $error("pin level read wrong");
  property p_pwm0; sfr_wr && sfr_addr == ADDR_MODE_BASE && sfr_wdata == 8'h02
    |-> ##[1:3] !module_pin_out[0]; endproperty
  a_pwm0: assert property (p_pwm0) else $error("pwm off not low");
  property p_low_width_overflow_flag; sfr_wr && sfr_addr == ADDR_PWM_CFG && sfr_wdata == 8'h60 |=> irq;
  endproperty
  a_low_width_overflow_flag: assert property (p_low_width_overflow_flag) else $error("overflow irq missing");
  c_irq: cover property ($rose(irq));
  c_tog: cover property ($rose(module_pin_out[0]));
  c_pin: cover property (sfr_rd && sfr_addr == ADDR_PIN_LEVEL);
endmodule
bind counter_array_capture_compare cacc_checker i_cacc_checker (.*);
`default_nettype wire

// file: cacc_pin_model.sv
// Pin partner: external level source and resolved pin wires
`timescale 1ns/100ps
`default_nettype none
module cacc_pin_model
  import cacc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [NUM_CH-1:0] ext_level,
  input  wire logic [NUM_CH-1:0] pin_out,
  input  wire logic [NUM_CH-1:0] pin_oe_n,
  output logic [NUM_CH-1:0]      pin
);
  logic [NUM_CH-1:0] drv_q = '0;
  logic [1:0]        age_q = 2'h0;
  // A new level waits until the old one has stood three clocks
  always_ff @(posedge clk) begin
    if (ext_level != drv_q && age_q == 2'h2) begin
      drv_q <= ext_level;
      age_q <= 2'h0;
    end else if (age_q != 2'h2) begin
      age_q <= age_q + 2'h1;
    end
  end
  assign pin = (pin_out & ~pin_oe_n) | (drv_q & pin_oe_n);
endmodule
`default_nettype wire

// file: counter_array_capture_compare_tb_top.sv
// Self-checking testbench for the counter array capture/compare block
`timescale 1ns/100ps
`default_nettype none
module counter_array_capture_compare_tb_top
  import cacc_pkg::*;
;
  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  logic [7:0]        sfr_addr = 8'h00;
  logic [7:0]        sfr_wdata = 8'h00;
  logic              sfr_wr = 1'b0;
  logic              sfr_rd = 1'b0;
  logic [7:0]        sfr_rdata;
  logic [NUM_CH-1:0] ext_level = '0;
  logic [NUM_CH-1:0] pin;
  logic [NUM_CH-1:0] pin_out;
  logic [NUM_CH-1:0] pin_oe_n;
  logic              irq;
  int                err_count = 0;
  int                comparisons = 0;
  initial forever #2.5 clk = ~clk;
  counter_array_capture_compare i_counter_array_capture_compare (
    .clk(clk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .timer0_ovf_tick(1'b0),
    .ext_osc_tick(1'b0), .rtc_tick(1'b0), .eci_pin(1'b0), .module_pin_in(pin),
    .module_pin_out(pin_out), .module_pin_oe_n(pin_oe_n), .irq(irq));
  cacc_pin_model i_cacc_pin_model (.clk(clk), .ext_level(ext_level), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin(pin));
  // ----
  // Bus and check tasks
  // ----
  task automatic results();
    if (err_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] a, input logic [15:0] e);
    comparisons++;
    if (a !== e) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, a, e);
    end
  endtask
  // Strobe drops for one idle edge so back-to-back calls never clash
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge clk);
    sfr_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    @(posedge clk);
    sfr_rd <= 1'b0;
    @(posedge clk);
    d = sfr_rdata;
  endtask
  task automatic wt(input logic sel, output int n);
    n = 0;
    while ((sel ? pin[0] : irq) !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 4000) err_count++;
  endtask
  task automatic arm(input logic [7:0] cfg);
    wr(ADDR_ARRAY_CTRL, 8'h00);
    wr(ADDR_CNT_LOW, 8'h00);
    wr(ADDR_CNT_HIGH, 8'h00);
    wr(ADDR_PWM_CFG, cfg);
    wr(ADDR_ARRAY_CTRL, 8'h40);
  endtask
  task automatic t_regs();
    logic [7:0] d;
    rd(ADDR_MODE_BASE, d);
    chk(d, MODE_RST);
    rd(8'h06, d);
    chk(d, 8'h00);
    wr(ADDR_MODE_BASE, 8'h49);
    rd(ADDR_MODE_BASE, d);
    chk(d, 8'h49);
    wr(ADDR_CPL_BASE, 8'h00);
    rd(ADDR_MODE_BASE, d);
    chk(d, 8'h09);
    wr(ADDR_CPH_BASE, 8'h01);
    rd(ADDR_MODE_BASE, d);
    chk(d, 8'h49);
  endtask
  task automatic t_timer();
    int n;
    logic [7:0] d;
    arm(8'h00);
    wt(1'b0, n);
    chk({15'h0, n >= 252 && n <= 262}, 16'h1);
    rd(ADDR_ARRAY_CTRL, d);
    chk(d, 8'h41);
    repeat (20) @(posedge clk);
    chk(irq, 1'b1);
    wr(ADDR_MODE_BASE, 8'h48);
    chk(irq, 1'b0);
  endtask
  task automatic t_ovf();
    int n;
    logic [7:0] d;
    wr(ADDR_PWM_CFG, 8'h60);
    rd(ADDR_PWM_CFG, d);
    chk(d, 8'h60);
    for (int c = 0; c < 4; c++) begin
      arm(8'h20 | 8'(c));
      wt(1'b0, n);
      chk({15'h0, n >= (256 << c) - 4 && n <= (256 << c) + 4}, 16'h1);
    end
    wr(ADDR_PWM_CFG, 8'h00);
  endtask
  task automatic t_hso();
    int n;
    logic [7:0] d;
    wr(ADDR_MODE_BASE, 8'h4C);
    chk(pin_oe_n[0], 1'b0);
    arm(8'h00);
    wt(1'b1, n);
    chk({15'h0, n >= 252 && n <= 262}, 16'h1);
    rd(ADDR_ARRAY_CTRL, d);
    chk(d, 8'h41);
    wr(ADDR_MODE_BASE, 8'h02);
    repeat (3) @(posedge clk);
    chk(pin[0], 1'b0);
  endtask
  task automatic t_cap();
    int n;
    logic [7:0] d;
    wr(ADDR_MODE_BASE + 8'h03, 8'h31);
    arm(8'h00);
    repeat (20) @(posedge clk);
    ext_level <= 6'h08;
    wt(1'b0, n);
    rd(ADDR_PIN_LEVEL, d);
    chk(d, 8'h08);
    rd(ADDR_CPH_BASE + 8'h03, d);
    chk(d, 8'h00);
    rd(ADDR_CPL_BASE + 8'h03, d);
    chk({15'h0, d >= 8'd20 && d <= 8'd32}, 16'h1);
    wr(ADDR_ARRAY_CTRL, 8'h40);
    ext_level <= 6'h00;
    wt(1'b0, n);
    chk({15'h0, n < 10}, 16'h1);
    rd(ADDR_PIN_LEVEL, d);
    chk(d, 8'h00);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    wr(ADDR_ARRAY_MODE, 8'h08);
    t_regs();
    t_timer();
    t_ovf();
    t_hso();
    t_cap();
    results();
  end
  initial begin
    #100000;
    err_count++;
    results();
  end
endmodule
`default_nettype wire
